// File: hw/aso_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the serial result port
// Assumes: Included by bare name from the design module and the bench
// Notes:   Definitions only
`ifndef ASO_DEFS_SVH
`define ASO_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define ASO_OFS_CTRL       5'h00
`define ASO_OFS_STATUS     5'h04
`define ASO_OFS_MASK       5'h08
`define ASO_OFS_FRAME      5'h0C
`define ASO_OFS_STATE      5'h10

// ==========================================================================
// Field positions
`define ASO_CTRL_EN_BIT    0
`define ASO_EV_DONE_BIT    0
`define ASO_EV_FRAME_BIT   1
`define ASO_EV_ABORT_BIT   2
`define ASO_STATE_CNT_LSB  4

// ==========================================================================
// Reset values
`define ASO_CTRL_RST       1'h1
`define ASO_MASK_RST       3'h0
`define ASO_FRAME_RST      24'hFFFFFF

// ==========================================================================
// Frame and code limits, bus response codes
`define ASO_LAST_FALL      5'h17
`define ASO_CODE_MIN       22'sh3E0000
`define ASO_CODE_MAX       22'sh11FFFF
`define ASO_RESP_OKAY      2'h0
`define ASO_RESP_SLVERR    2'h2

`endif

// File: hw/aso_pkg.sv
// Purpose: Types shared by the serial result port
// Assumes: aso_defs.svh holds the register numbers; the state codes are set here
// Notes:   Frame layout is the 24-bit word as shifted, bit 23 first
package aso_pkg;

	// ======================================================================
	// Converter states, Gray along convert, sleep, shift
	typedef enum logic [1:0]
	{
		ASO_ST_CONV  = 2'h0,
		ASO_ST_SLEEP = 2'h1,
		ASO_ST_SHIFT = 2'h3
	} aso_state_t;

	// ======================================================================
	// Output word
	typedef struct packed
	{
		logic        eoc_n;
		logic        filler_bit;
		logic        sign_flag;
		logic        out_of_range_flag;
		logic [19:0] result;
	} aso_frame_t;

	// ======================================================================
	// Sticky events
	typedef struct packed
	{
		logic abort;
		logic frame;
		logic done;
	} aso_events_t;

endpackage : aso_pkg

// File: hw/aso_result_port.sv
// Purpose: Serial result output port of a delta-sigma converter with AXI4-Lite control
// Assumes: Converter core on ref_clk_i; select and serial clock are asynchronous pins
// Notes:   Serial clock is sampled, so it must be well below a quarter of ref_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "aso_defs.svh"

module aso_result_port
	import aso_pkg::*;
#(
	parameter int ADDR_W = 5
)
(
	// Clock and reset
	input  wire logic               ref_clk_i,
	input  wire logic               arst_n_i,
	// Serial pins
	input  wire logic               converter_select_n_i,
	input  wire logic               sck_i,
	output logic                    sdo_o,
	output logic                    sdo_oe_o,
	// Converter core
	input  wire logic               conv_done_i,
	input  wire logic signed [21:0] conv_code_i,
	output logic                    conv_start_o,
	// AXI4-Lite slave
	input  wire logic               s_axi_awvalid_i,
	output logic                    s_axi_awready_o,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire logic               s_axi_wvalid_i,
	output logic                    s_axi_wready_o,
	input  wire logic [31:0]        s_axi_wdata_i,
	input  wire logic [3:0]         s_axi_wstrb_i,
	output logic                    s_axi_bvalid_o,
	input  wire logic               s_axi_bready_i,
	output logic [1:0]              s_axi_bresp_o,
	input  wire logic               s_axi_arvalid_i,
	output logic                    s_axi_arready_o,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,
	output logic                    s_axi_rvalid_o,
	input  wire logic               s_axi_rready_i,
	output logic [31:0]             s_axi_rdata_o,
	output logic [1:0]              s_axi_rresp_o,
	// Interrupt
	output logic                    irq_o
);

	if (ADDR_W < 5)
	begin : g_addr_check
		$error("ADDR_W must be at least 5");
	end

	// ======================================================================
	// Pin synchronisers
	logic sel_s1_reg;
	logic sel_s2_reg;
	logic sel_d_reg;
	logic sck_s1_reg;
	logic sck_s2_reg;
	logic sck_d_reg;
	logic sel_low;
	logic sel_rise;
	logic sck_fall;

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sel_s1_reg <= 1'h1;
			sel_s2_reg <= 1'h1;
			sel_d_reg  <= 1'h1;
			sck_s1_reg <= 1'h0;
			sck_s2_reg <= 1'h0;
			sck_d_reg  <= 1'h0;
		end
		else
		begin
			sel_s1_reg <= converter_select_n_i;
			sel_s2_reg <= sel_s1_reg;
			sel_d_reg  <= sel_s2_reg;
			sck_s1_reg <= sck_i;
			sck_s2_reg <= sck_s1_reg;
			sck_d_reg  <= sck_s2_reg;
		end
	end

	assign sel_low  = !sel_s2_reg;
	assign sel_rise = sel_s2_reg && !sel_d_reg;
	// Edges only count while selected; a high select leaves the shifter deaf
	assign sck_fall = sel_low && sck_d_reg && !sck_s2_reg;

	// ======================================================================
	// Result formatting
	function automatic aso_frame_t fmt_code(input logic signed [21:0] code);
		logic signed [21:0] c;
		aso_frame_t         f;
		c = code;
		if (code < `ASO_CODE_MIN)
			c = `ASO_CODE_MIN;
		else if (code > `ASO_CODE_MAX)
			c = `ASO_CODE_MAX;
		f.eoc_n             = 1'h0;
		f.filler_bit        = 1'h0;
		f.sign_flag         = !c[21];
		f.out_of_range_flag = c[21] || c[20];
		f.result            = c[19:0];
		return f;
	endfunction : fmt_code

	// ======================================================================
	// Converter sequence and shifter
	aso_state_t  state_reg;
	aso_state_t  state_next;
	logic [23:0] shreg_reg;
	logic [23:0] shreg_next;
	logic [4:0]  cnt_reg;
	logic [4:0]  cnt_next;
	logic        pend_reg;
	logic        pend_next;
	logic        start_reg;
	logic        start_next;
	logic        sdo_reg;
	logic        sdo_next;
	logic        oe_reg;
	logic [23:0] frame_reg;
	logic [23:0] frame_next;
	logic        ctrl_en_reg;
	aso_events_t ev;

	always_comb
	begin
		state_next = state_reg;
		shreg_next = shreg_reg;
		cnt_next   = cnt_reg;
		pend_next  = pend_reg;
		frame_next = frame_reg;
		ev         = '0;
		// Software may hold off the next conversion; the request waits
		start_next = pend_reg && ctrl_en_reg;
		if (start_next)
			pend_next = 1'h0;
		case (state_reg)
			ASO_ST_CONV:
			begin
				if (conv_done_i && !pend_reg)
				begin
					shreg_next = fmt_code(conv_code_i);
					frame_next = shreg_next;
					state_next = ASO_ST_SLEEP;
					ev.done    = 1'h1;
				end
			end
			ASO_ST_SLEEP:
			begin
				if (sck_fall)
				begin
					shreg_next = {shreg_reg[22:0], 1'h1};
					cnt_next   = 5'h1;
					state_next = ASO_ST_SHIFT;
				end
			end
			ASO_ST_SHIFT:
			begin
				if (sel_rise)
				begin
					state_next = ASO_ST_CONV;
					pend_next  = 1'h1;
					cnt_next   = 5'h0;
					ev.abort   = 1'h1;
				end
				else if (sck_fall && cnt_reg == `ASO_LAST_FALL)
				begin
					state_next = ASO_ST_CONV;
					pend_next  = 1'h1;
					cnt_next   = 5'h0;
					ev.frame   = 1'h1;
				end
				else if (sck_fall)
				begin
					shreg_next = {shreg_reg[22:0], 1'h1};
					cnt_next   = cnt_reg + 5'h1;
				end
			end
			default:
			begin
				state_next = ASO_ST_CONV;
			end
		endcase
		// Converting shows the done-low level high; the tail bits come out high too
		sdo_next = (state_next == ASO_ST_CONV) ? 1'h1 : shreg_next[23];
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg <= ASO_ST_CONV;
			shreg_reg <= `ASO_FRAME_RST;
			cnt_reg   <= 5'h0;
			pend_reg  <= 1'h1;
			start_reg <= 1'h0;
			sdo_reg   <= 1'h1;
			oe_reg    <= 1'h0;
			frame_reg <= `ASO_FRAME_RST;
		end
		else
		begin
			state_reg <= state_next;
			shreg_reg <= shreg_next;
			cnt_reg   <= cnt_next;
			pend_reg  <= pend_next;
			start_reg <= start_next;
			sdo_reg   <= sdo_next;
			oe_reg    <= sel_low;
			frame_reg <= frame_next;
		end
	end

	// ======================================================================
	// AXI4-Lite slave and registers
	logic        awr_reg, awr_next;
	logic        wr_reg, wr_next;
	logic        bv_reg, bv_next;
	logic [1:0]  br_reg, br_next;
	logic        arr_reg, arr_next;
	logic        rv_reg, rv_next;
	logic [31:0] rd_reg, rd_next;
	logic [1:0]  rr_reg, rr_next;
	logic        awh_reg, awh_next;
	logic        wh_reg, wh_next;
	logic [ADDR_W-1:0] wa_reg, wa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0]  ws_reg, ws_next;
	logic        ctrl_en_next;
	aso_events_t mask_reg, mask_next;
	aso_events_t stat_reg, stat_next;
	aso_events_t stat_clr;
	logic        irq_reg, irq_next;

	always_comb
	begin
		awh_next     = awh_reg;
		wh_next      = wh_reg;
		wa_next      = wa_reg;
		wd_next      = wd_reg;
		ws_next      = ws_reg;
		bv_next      = bv_reg;
		br_next      = br_reg;
		rv_next      = rv_reg;
		rd_next      = rd_reg;
		rr_next      = rr_reg;
		ctrl_en_next = ctrl_en_reg;
		mask_next    = mask_reg;
		stat_clr     = '0;
		if (s_axi_awvalid_i && awr_reg)
		begin
			awh_next = 1'h1;
			wa_next  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wr_reg)
		begin
			wh_next = 1'h1;
			wd_next = s_axi_wdata_i;
			ws_next = s_axi_wstrb_i;
		end
		if (awh_reg && wh_reg && !bv_reg)
		begin
			awh_next = 1'h0;
			wh_next  = 1'h0;
			bv_next  = 1'h1;
			br_next  = `ASO_RESP_OKAY;
			if (wa_reg[4:2] == 3'(`ASO_OFS_CTRL >> 2))
			begin
				if (ws_reg[0])
					ctrl_en_next = wd_reg[`ASO_CTRL_EN_BIT];
			end
			else if (wa_reg[4:2] == 3'(`ASO_OFS_MASK >> 2))
			begin
				if (ws_reg[0])
					mask_next = wd_reg[2:0];
			end
			else
				br_next = `ASO_RESP_SLVERR;
		end
		if (bv_reg && s_axi_bready_i)
			bv_next = 1'h0;
		if (rv_reg && s_axi_rready_i)
			rv_next = 1'h0;
		if (s_axi_arvalid_i && arr_reg)
		begin
			rv_next = 1'h1;
			rd_next = 32'h0;
			rr_next = `ASO_RESP_OKAY;
			if (s_axi_araddr_i[4:2] == 3'(`ASO_OFS_CTRL >> 2))
				rd_next[`ASO_CTRL_EN_BIT] = ctrl_en_reg;
			else if (s_axi_araddr_i[4:2] == 3'(`ASO_OFS_STATUS >> 2))
			begin
				rd_next[2:0] = stat_reg;
				stat_clr     = stat_reg;
			end
			else if (s_axi_araddr_i[4:2] == 3'(`ASO_OFS_MASK >> 2))
				rd_next[2:0] = mask_reg;
			else if (s_axi_araddr_i[4:2] == 3'(`ASO_OFS_FRAME >> 2))
				rd_next[23:0] = frame_reg;
			else if (s_axi_araddr_i[4:2] == 3'(`ASO_OFS_STATE >> 2))
			begin
				rd_next[1:0] = state_reg;
				rd_next[`ASO_STATE_CNT_LSB +: 5] = cnt_reg;
			end
			else
				rr_next = `ASO_RESP_SLVERR;
		end
		// Upper address bits beyond the map also answer with an error
		if (s_axi_arvalid_i && arr_reg && s_axi_araddr_i > ADDR_W'(`ASO_OFS_STATE))
		begin
			rr_next = `ASO_RESP_SLVERR;
			rd_next = 32'h0;
		end
		awr_next  = !awh_next && !bv_next;
		wr_next   = !wh_next && !bv_next;
		arr_next  = !rv_next;
		// A set in the same cycle as the read-clear survives
		stat_next = (stat_reg & ~stat_clr) | ev;
		irq_next  = |(stat_next & mask_next);
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			awr_reg     <= 1'h0;
			wr_reg      <= 1'h0;
			bv_reg      <= 1'h0;
			br_reg      <= 2'h0;
			arr_reg     <= 1'h0;
			rv_reg      <= 1'h0;
			rd_reg      <= 32'h0;
			rr_reg      <= 2'h0;
			awh_reg     <= 1'h0;
			wh_reg      <= 1'h0;
			wa_reg      <= '0;
			wd_reg      <= 32'h0;
			ws_reg      <= 4'h0;
			ctrl_en_reg <= `ASO_CTRL_RST;
			mask_reg    <= `ASO_MASK_RST;
			stat_reg    <= '0;
			irq_reg     <= 1'h0;
		end
		else
		begin
			awr_reg     <= awr_next;
			wr_reg      <= wr_next;
			bv_reg      <= bv_next;
			br_reg      <= br_next;
			arr_reg     <= arr_next;
			rv_reg      <= rv_next;
			rd_reg      <= rd_next;
			rr_reg      <= rr_next;
			awh_reg     <= awh_next;
			wh_reg      <= wh_next;
			wa_reg      <= wa_next;
			wd_reg      <= wd_next;
			ws_reg      <= ws_next;
			ctrl_en_reg <= ctrl_en_next;
			mask_reg    <= mask_next;
			stat_reg    <= stat_next;
			irq_reg     <= irq_next;
		end
	end

	// ======================================================================
	// Outputs
	assign sdo_o           = sdo_reg;
	assign sdo_oe_o        = oe_reg;
	assign conv_start_o    = start_reg;
	assign s_axi_awready_o = awr_reg;
	assign s_axi_wready_o  = wr_reg;
	assign s_axi_bvalid_o  = bv_reg;
	assign s_axi_bresp_o   = br_reg;
	assign s_axi_arready_o = arr_reg;
	assign s_axi_rvalid_o  = rv_reg;
	assign s_axi_rdata_o   = rd_reg;
	assign s_axi_rresp_o   = rr_reg;
	assign irq_o           = irq_reg;

	// ======================================================================
	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence s_last_fall;
		state_reg == ASO_ST_SHIFT && !sel_rise && sck_fall
			&& cnt_reg == `ASO_LAST_FALL && ctrl_en_reg;
	endsequence

	sequence s_new_conv;
		state_reg == ASO_ST_CONV && sdo_reg ##[1:2] conv_start_o;
	endsequence

	chk_frame_end: assert property (s_last_fall |=> s_new_conv)
		else $error("frame did not end with a new conversion");

	chk_status_head: assert property (state_reg == ASO_ST_CONV && conv_done_i && !pend_reg
		|=> shreg_reg[23:22] == 2'h0 && !sdo_reg)
		else $error("frame head not done-low and filler low");

	chk_result_field: assert property (state_reg == ASO_ST_CONV && conv_done_i && !pend_reg
		&& conv_code_i >= 0 && conv_code_i <= `ASO_CODE_MAX
		|=> shreg_reg[19:0] == $past(conv_code_i[19:0]))
		else $error("result field differs from code");

	chk_conv_level: assert property (state_reg == ASO_ST_CONV && !conv_done_i && sel_low
		|=> sdo_reg && oe_reg)
		else $error("data not high while converting");

	chk_range_flags: assert property (state_reg == ASO_ST_CONV && conv_done_i && !pend_reg
		&& conv_code_i > `ASO_CODE_MAX
		|=> shreg_reg[21:20] == 2'h3 && shreg_reg[19:0] == 20'h1FFFF)
		else $error("over-range word wrong");

	chk_ref_edge: assert property (state_reg == ASO_ST_CONV && conv_done_i && !pend_reg
		&& conv_code_i == 22'sh100000
		|=> shreg_reg[20] && shreg_reg[19:0] == 20'h0)
		else $error("one step above reference wrong");

	// The abort itself clears the count, so only the cycles after it must hold still
	chk_hiz_ignore: assert property (sel_s2_reg && !sel_rise
		|=> !oe_reg && $stable(cnt_reg))
		else $error("select high but pin driven or shifter moved");

	chk_shift_step: assert property (state_reg == ASO_ST_SHIFT && !sel_rise && sck_fall
		&& cnt_reg < `ASO_LAST_FALL
		|=> cnt_reg == $past(cnt_reg) + 5'h1 && sdo_reg == $past(shreg_reg[22]))
		else $error("shift step wrong");

	chk_sleep_hold: assert property (state_reg == ASO_ST_SLEEP && !sck_fall
		|=> $stable(shreg_reg))
		else $error("result moved during sleep");

	chk_abort: assert property (state_reg == ASO_ST_SHIFT && sel_rise && ctrl_en_reg
		|=> s_new_conv)
		else $error("abort did not restart conversion");

	chk_irq_level: assert property (irq_o == |(stat_reg & mask_reg))
		else $error("interrupt level wrong");

endmodule : aso_result_port

`default_nettype wire

// File: bench/aso_host_model.sv
// Purpose: Serial host that selects the port and clocks result frames out of it
// Assumes: Serial clock made here, unrelated in phase to ref_clk_i, idle low
// Notes:   Low phase 120 ns, high 40 ns, so data has settled well before each rise
`timescale 1ns/1ps
`default_nettype none

module aso_host_model
(
	// Serial pins
	output logic      converter_select_n_o,
	output logic      sck_o,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	logic line_level;
	logic last_level;

	// A released data line shows the inverse of its last value, never a stale copy
	initial last_level = 1'b1;
	always @(sdo_i or sdo_oe_i)
		if (sdo_oe_i)
			last_level = sdo_i;
	assign line_level = sdo_oe_i ? sdo_i : ~last_level;

	initial
	begin
		converter_select_n_o = 1'b1;
		sck_o = 1'b0;
	end

	task automatic select_low;
		#37 converter_select_n_o = 1'b0;
		#200;
	endtask : select_low

	// Raising select mid-frame abandons the transfer
	task automatic deselect;
		#40 converter_select_n_o = 1'b1;
		#100;
	endtask : deselect

	task automatic shift(input int n, output logic [31:0] w);
		w = 32'h0;
		repeat (n)
		begin
			#120 sck_o = 1'b1;
			w = {w[30:0], line_level};
			#40 sck_o = 1'b0;
		end
	endtask : shift
endmodule : aso_host_model

`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench of the serial result port
// Assumes: Host model drives the serial pins; bench drives core and register bus
// Notes:   Mask enables only the abort event, so irq must stay low on normal frames
`timescale 1ns/1ps
`default_nettype none
`include "aso_defs.svh"

module tb;
	logic               ref_clk;
	logic               arst_n;
	logic               converter_select_n;
	logic               sck;
	logic               sdo;
	logic               sdo_oe;
	logic               conv_done;
	logic signed [21:0] conv_code;
	logic               conv_start;
	logic               awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready, irq;
	logic [4:0]         awaddr, araddr;
	logic [31:0]        wdata, rdata, w, d;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp, r;
	logic [23:0]        exp;
	logic signed [21:0] codes [7];
	int                 fails = 0;
	int                 total_checks = 0;
	int                 starts = 0;
	int                 s0, nb;

	aso_result_port dut_u (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
		.converter_select_n_i(converter_select_n), .sck_i(sck), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .conv_done_i(conv_done), .conv_code_i(conv_code),
		.conv_start_o(conv_start), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.irq_o(irq));

	aso_host_model host_u (.converter_select_n_o(converter_select_n), .sck_o(sck),
		.sdo_i(sdo), .sdo_oe_i(sdo_oe));

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
		if (conv_start === 1'b1)
			starts <= starts + 1;

	// ======================================================================
	// Helpers
	function automatic logic [23:0] fmt(input logic signed [21:0] c);
		logic signed [21:0] k;
		k = c;
		if (k > `ASO_CODE_MAX)
			k = `ASO_CODE_MAX;
		if (k < `ASO_CODE_MIN)
			k = `ASO_CODE_MIN;
		fmt = {1'b0, 1'b0, k >= 0, (k < 0) || (k > 22'sh0FFFFF), k[19:0]};
	endfunction : fmt

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic stop_test;
		$display("Checks made %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h, seen %h", what, e, g);
			fails++;
		end
		if (what == "timeout")
			stop_test();
	endtask : chk

	task automatic axi_write(input logic [4:0] a, input logic [31:0] dat, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge ref_clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= dat;
		wstrb <= 4'hF;
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			rs = bresp;
		end
		while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		if (n >= 100)
			chk("timeout", 32'h0, 32'h1);
	endtask : axi_write

	task automatic axi_read(input logic [4:0] a, output logic [31:0] dat, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge ref_clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			dat = rdata;
			rs = rresp;
		end
		while (rvalid !== 1'b1 && n < 100);
		rready <= 1'b0;
		if (n >= 100)
			chk("timeout", 32'h0, 32'h1);
	endtask : axi_read

	task automatic pulse_done(input logic signed [21:0] c);
		@(posedge ref_clk);
		conv_done <= 1'b1;
		conv_code <= c;
		@(posedge ref_clk);
		conv_done <= 1'b0;
	endtask : pulse_done

	task automatic wait_start(input int s);
		int n;
		n = 0;
		while (starts == s && n < 50)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (starts == s)
			chk("timeout", 32'h0, 32'h1);
	endtask : wait_start

	// ======================================================================
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		conv_done = 1'b0;
		conv_code = 22'sh000000;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		codes = '{22'sh0FFFFF, 22'sh100000, 22'sh1FFFFF, 22'sh000000,
			22'sh3FFFFF, 22'sh3DFFFD, 22'sh0C0000};
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		tick(2);
		axi_read(`ASO_OFS_CTRL, d, r);
		chk("ctrl reset", 32'h1, d);
		axi_read(`ASO_OFS_MASK, d, r);
		chk("mask reset", 32'h0, d);
		axi_read(`ASO_OFS_FRAME, d, r);
		chk("frame reset", 32'hFFFFFF, d);
		axi_read(`ASO_OFS_STATE, d, r);
		chk("state reset", 32'h0, d);
		axi_read(5'h14, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", 32'h2, {30'h0, r});
		axi_write(`ASO_OFS_FRAME, 32'h0, r);
		chk("read-only resp", 32'h2, {30'h0, r});
		axi_write(`ASO_OFS_MASK, 32'h4, r);
		axi_read(`ASO_OFS_MASK, d, r);
		chk("mask", 32'h4, d);
		for (int i = 0; i < 7; i++)
		begin
			exp = fmt(codes[i]);
			nb = (i == 6) ? 32 : 24;
			if (i == 0)
			begin
				pulse_done(codes[i]);
				tick(1);
				host_u.shift(5, w);
				tick(2);
				chk("deselected enable", 32'h0, {31'h0, sdo_oe});
				host_u.select_low();
				tick(1);
				chk("done level", 32'h0, {31'h0, sdo});
			end
			else
			begin
				host_u.select_low();
				tick(1);
				chk("busy level", 32'h1, {31'h0, sdo});
				pulse_done(codes[i]);
				tick(2);
				chk("done edge", 32'h0, {31'h0, sdo});
			end
			s0 = starts;
			if (i == 6)
			begin
				axi_write(`ASO_OFS_CTRL, 32'h0, r);
				tick(1);
			end
			host_u.shift(nb, w);
			chk("frame word", (nb == 24) ? {8'h0, exp} : {exp, 8'hFF}, w);
			tick(6);
			chk("level after frame", 32'h1, {31'h0, sdo});
			if (i == 6)
			begin
				chk("held start", s0, starts);
				axi_write(`ASO_OFS_CTRL, 32'h1, r);
			end
			wait_start(s0);
			chk("masked irq", 32'h0, {31'h0, irq});
			axi_read(`ASO_OFS_STATUS, d, r);
			chk("status", 32'h3, d);
			axi_read(`ASO_OFS_FRAME, d, r);
			chk("held word", {8'h0, exp}, d);
			host_u.deselect();
		end
		host_u.select_low();
		pulse_done(22'sh000005);
		exp = fmt(22'sh000005);
		tick(1);
		host_u.shift(10, w);
		chk("partial word", {22'h0, exp[23:14]}, w);
		chk("irq before abort", 32'h0, {31'h0, irq});
		s0 = starts;
		host_u.deselect();
		wait_start(s0);
		tick(3);
		chk("abort irq", 32'h1, {31'h0, irq});
		axi_read(`ASO_OFS_STATUS, d, r);
		chk("abort status", 32'h5, d);
		tick(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		stop_test();
	end
endmodule : tb

`default_nettype wire
